// ==== design/rsc_strap_config.sv ====
// Top of the strap configuration decoder and switch control.
// Assumes strap indices from an analog quantiser, synchronous to pclk,
// and an APB master for software access.
//
// Function
// - First strap resolves into one of eight codes.
// - Second strap resolves into one of sixteen codes, open included.
// - Straps sampled only at initiation, then settings frozen.
// - Initiation ends under 1 ms; no switching before it ends.
// - First-strap codes 0..17.8k set unpaired per-channel current capability.
// - First-strap codes 21.5k, 26.1k, 31.6k select channel pairing.
// - Second-strap lower eight codes manual, upper eight grouped sequence.
// - Timer multiplier one or eight from the second strap.
// - Four second-strap codes select automatic power-save, others forced.
// - Second strap picks general-purpose pin function.
// - Operating mode applies identically to all unpaired channels.
// - Forced mode switches every cycle, low side stays on below zero.
// - Automatic mode drops frequency at light load, low side off at zero.
// - High side on at cycle start, off at peak, then low side.
// - Power-save bursts until regulation returns; switches off when idle.
// - Paired channels run forced mode; no sequence mode when paired.
// - Sequence mode turns first enable into grouped turn-on for all.
`timescale 1ns/1ns
module rsc_strap_config
	import rsc_pkg::*;
#(
	parameter int INIT_COUNT = INIT_CYCLES
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  rsc_apb_req_t               apb_req,
	output rsc_apb_rsp_t               apb_rsp,
	// Quantised strap indices
	input  wire logic [CAP_IDX_W-1:0]  capability_strap,
	input  wire logic [FUNC_IDX_W-1:0] function_strap,
	// Enable pins, first one doubles as grouped turn-on
	input  wire logic [NCH-1:0]        en_pin,
	// Analog events per channel
	input  rsc_sense_t                 sense,
	// Switch drives
	output logic [NCH-1:0]             hs_drive,
	output logic [NCH-1:0]             ls_drive,
	// Frozen configuration
	output logic                       cfg_valid,
	output rsc_cfg_t                   cfg,
	output logic [NCH-1:0]             forced_fixed_freq_mode
);
	localparam logic [INIT_W-1:0] LATCH_AT = INIT_W'(INIT_COUNT - 3);

	rsc_init_t               init_reg;
	rsc_init_t               init_next;
	logic [INIT_W-1:0]       init_cnt_reg;
	logic [CAP_IDX_W-1:0]    cap_idx_reg;
	logic [FUNC_IDX_W-1:0]   func_idx_reg;
	rsc_cfg_t                cfg_dec;
	rsc_cfg_t                cfg_reg;
	logic [NCH-1:0]          chan_en_reg;
	logic [31:0]             prdata_reg;

	// Initiation sequence: settle, latch once, run
	always_comb begin
		init_next = init_reg;
		case (init_reg)
			ST_RESET:  init_next = ST_SETTLE;
			ST_SETTLE: begin
				if (init_cnt_reg >= LATCH_AT)
					init_next = ST_LATCH;
			end
			ST_LATCH:  init_next = ST_RUN;
			ST_RUN:    init_next = ST_RUN;
			default:   init_next = ST_RESET;
		endcase
	end

	// Init state and cycle count; count stops once running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_reg     <= ST_RESET;
			init_cnt_reg <= '0;
		end else begin
			init_reg <= init_next;
			if (init_reg != ST_RUN)
				init_cnt_reg <= init_cnt_reg + 1'b1;
		end
	end

	// Straps caught once, at the latch state only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_idx_reg  <= '0;
			func_idx_reg <= '0;
		end else if (init_reg == ST_LATCH) begin
			cap_idx_reg  <= capability_strap;
			func_idx_reg <= function_strap;
		end
	end

	// Table decode of the live straps; the latch edge keeps index and settings together
	rsc_strap_decode u_decode (
		.cap_idx  (capability_strap),
		.func_idx (function_strap),
		.cfg      (cfg_dec)
	);

	// Decoded word registered so outputs come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_reg <= '0;
		else if (init_reg == ST_LATCH)
			cfg_reg <= cfg_dec;
	end

	assign cfg       = cfg_reg;
	assign cfg_valid = (init_reg == ST_RUN);

	// Mode per channel: global setting, paired channels forced
	wire logic [NCH-1:0] pair_mask = {{2{cfg_reg.pair34}}, {2{cfg_reg.pair12}}};
	wire logic [NCH-1:0] psm_ch    = {NCH{cfg_reg.power_save_mode}} & ~pair_mask;
	assign forced_fixed_freq_mode = ~psm_ch;

	// Enable routing: grouped turn-on in sequence mode, slaves follow masters
	wire logic [NCH-1:0] raw_req = cfg_reg.seq_mode ? {NCH{en_pin[0]}} : en_pin;
	wire logic [NCH-1:0] chan_req = {
		cfg_reg.pair34 ? raw_req[2] : raw_req[3],
		raw_req[2],
		cfg_reg.pair12 ? raw_req[0] : raw_req[1],
		raw_req[0]
	};
	// Nothing may switch before the configuration is valid
	wire logic [NCH-1:0] run_ch = {NCH{cfg_valid}} & chan_req & chan_en_reg;

	// One switch sequencer per channel
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			rsc_switch_seq u_seq (
				.pclk       (pclk),
				.presetn    (presetn),
				.run        (run_ch[gi]),
				.psm_cfg    (psm_ch[gi]),
				.osc_tick   (sense.osc_tick[gi]),
				.peak_trip  (sense.peak_trip[gi]),
				.zero_cross (sense.zero_cross[gi]),
				.below_reg  (sense.below_reg[gi]),
				.light_load (sense.light_load[gi]),
				.hs_on      (hs_drive[gi]),
				.ls_on      (ls_drive[gi])
			);
		end
	endgenerate

	// APB decode
	wire logic setup_ph  = apb_req.psel & ~apb_req.penable;
	wire logic access_ph = apb_req.psel & apb_req.penable;
	wire logic hit_stat  = (apb_req.paddr == ADDR_STATUS);
	wire logic hit_strap = (apb_req.paddr == ADDR_STRAP);
	wire logic hit_dec   = (apb_req.paddr == ADDR_DECODE);
	wire logic hit_en    = (apb_req.paddr == ADDR_CHAN_EN);
	wire logic hit_drv   = (apb_req.paddr == ADDR_DRIVE);
	wire logic addr_hit  = hit_stat | hit_strap | hit_dec | hit_en | hit_drv;
	wire logic wr_en     = access_ph & apb_req.pwrite & hit_en;

	// Read selection; unmapped reads return zero
	wire logic [31:0] rd_val =
		hit_stat  ? {28'h0, init_reg} << 1 | {31'h0, cfg_valid} :
		hit_strap ? {24'h0, func_idx_reg, 1'b0, cap_idx_reg} :
		hit_dec   ? {13'h0, cfg_reg} :
		hit_en    ? {28'h0, chan_en_reg} :
		hit_drv   ? {24'h0, ls_drive, hs_drive} :
		32'h0;

	// Read data captured in setup, so the access needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= '0;
		else if (setup_ph)
			prdata_reg <= rd_val;
	end

	// Channel enable mask, write-only effect at access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			chan_en_reg <= CHAN_EN_RST;
		else if (wr_en)
			chan_en_reg <= apb_req.pwdata[NCH-1:0];
	end

	assign apb_rsp.prdata  = prdata_reg;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = access_ph & ~addr_hit;

	// Helper: strap values seen at the latch edge
	logic [CAP_IDX_W-1:0]  cap_seen_reg;
	logic [FUNC_IDX_W-1:0] func_seen_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_seen_reg  <= '0;
			func_seen_reg <= '0;
		end else if (init_reg == ST_LATCH) begin
			cap_seen_reg  <= capability_strap;
			func_seen_reg <= function_strap;
		end
	end

	cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_valid && $past(cfg_valid) |-> $stable(cfg_reg) && $stable(cap_idx_reg))
		else $error("configuration changed after initiation");

	init_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cfg_valid |-> init_cnt_reg < INIT_W'(INIT_COUNT))
		else $error("initiation overran its time");

	drive_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cfg_valid |-> hs_drive == '0 && ls_drive == '0)
		else $error("switch driven before configuration valid");

	valid_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cfg_valid) |-> $past(init_reg) == ST_LATCH
			&& cap_idx_reg == cap_seen_reg && func_idx_reg == func_seen_reg)
		else $error("valid raised without latched straps");

	pair_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_valid && (cfg_reg.pair12 || cfg_reg.pair34)
			|-> !cfg_reg.seq_mode && (psm_ch & pair_mask) == '0)
		else $error("paired channel not in forced mode");

	pair_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_valid |-> cfg_reg.pair12 == (cap_idx_reg == 3'h5 || cap_idx_reg == 3'h7)
			&& cfg_reg.pair34 == (cap_idx_reg >= 3'h6))
		else $error("pairing does not match capability code");

	psm_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_valid |-> cfg_reg.power_save_mode == (func_idx_reg[1:0] == 2'h3))
		else $error("power-save selection wrong");

	grouped_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_valid && cfg_reg.seq_mode |-> run_ch == ({NCH{en_pin[0]}} & chan_en_reg))
		else $error("grouped turn-on not applied");

	seq_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_valid && !cfg_reg.pair12 && !cfg_reg.pair34
			|-> cfg_reg.seq_mode == func_idx_reg[3])
		else $error("enable mode does not match function code");
endmodule

// ==== design/rsc_pkg.sv ====
// Shared constants, types and register map of the strap configuration decoder.
// Assumes a single 20 MHz clock and a synchronous analog strap quantiser.
package rsc_pkg;
	// Clock and initiation timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int INIT_TIME_NS  = 1000000;
	localparam int INIT_CYCLES   = INIT_TIME_NS / CLK_PERIOD_NS; // Longest, rounds down
	localparam int INIT_W        = 15;

	// Strap index widths
	localparam int CAP_IDX_W  = 3;
	localparam int FUNC_IDX_W = 4;
	localparam int NCH        = 4;

	// Function strap index fields, rows in ascending table order
	localparam int FS_SEQ_BIT   = 3;
	localparam int FS_X8_BIT    = 2;
	localparam logic [1:0] FS_PSM_SEL = 2'h3;

	// Capability codes in amperes
	localparam logic [2:0] AMP_1A = 3'h1;
	localparam logic [2:0] AMP_2A = 3'h2;
	localparam logic [2:0] AMP_4A = 3'h4;

	// APB register byte addresses
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_STRAP   = 8'h04;
	localparam logic [7:0] ADDR_DECODE  = 8'h08;
	localparam logic [7:0] ADDR_CHAN_EN = 8'h0c;
	localparam logic [7:0] ADDR_DRIVE   = 8'h10;
	localparam logic [3:0] CHAN_EN_RST  = 4'hf;

	// General-purpose pin function
	typedef enum logic [1:0] {
		GPIO_POWER_GOOD = 2'h0,
		GPIO_SYNC_IN    = 2'h1,
		GPIO_CLK_OUT    = 2'h2,
		GPIO_UNDERVOLT  = 2'h3
	} rsc_gpio_t;

	// Decoded configuration, frozen after initiation
	typedef struct packed {
		logic [NCH-1:0][2:0] amps;
		logic                pair12;
		logic                pair34;
		logic                seq_mode;
		logic                timer_x8;
		logic                power_save_mode;
		rsc_gpio_t           gpio;
	} rsc_cfg_t;

	// Per-channel analog events, one bit per channel
	typedef struct packed {
		logic [NCH-1:0] osc_tick;
		logic [NCH-1:0] peak_trip;
		logic [NCH-1:0] zero_cross;
		logic [NCH-1:0] below_reg;
		logic [NCH-1:0] light_load;
	} rsc_sense_t;

	// APB request and answer
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rsc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rsc_apb_rsp_t;

	// Initiation states
	typedef enum logic [3:0] {
		ST_RESET  = 4'b0001,
		ST_SETTLE = 4'b0010,
		ST_LATCH  = 4'b0100,
		ST_RUN    = 4'b1000
	} rsc_init_t;

	// Switch states
	typedef enum logic [2:0] {
		SW_IDLE = 3'b001,
		SW_HIGH = 3'b010,
		SW_LOW  = 3'b100
	} rsc_sw_t;
endpackage

// ==== design/rsc_strap_decode.sv ====
// Combinational decode of the two strap indices into settings.
// Assumes the caller registers the result at the latch edge only.
`timescale 1ns/1ns
module rsc_strap_decode
	import rsc_pkg::*;
(
	// Live strap indices from the quantiser
	input  wire logic [CAP_IDX_W-1:0]  cap_idx,
	input  wire logic [FUNC_IDX_W-1:0] func_idx,
	// Decoded settings
	output rsc_cfg_t                   cfg
);
	// Capability table, eight codes: amps and pairing
	function automatic logic [13:0] cap_lookup(input logic [CAP_IDX_W-1:0] idx);
		case (idx)
			3'h0: cap_lookup = {AMP_2A, AMP_2A, AMP_4A, AMP_4A, 2'b00};
			3'h1: cap_lookup = {AMP_2A, AMP_2A, AMP_2A, AMP_4A, 2'b00};
			3'h2: cap_lookup = {AMP_1A, AMP_1A, AMP_2A, AMP_4A, 2'b00};
			3'h3: cap_lookup = {AMP_2A, AMP_2A, AMP_2A, AMP_2A, 2'b00};
			3'h4: cap_lookup = {AMP_1A, AMP_1A, AMP_2A, AMP_2A, 2'b00};
			3'h5: cap_lookup = {AMP_2A, AMP_2A, AMP_4A, AMP_4A, 2'b10};
			3'h6: cap_lookup = {AMP_2A, AMP_2A, AMP_4A, AMP_4A, 2'b01};
			default: cap_lookup = {AMP_2A, AMP_2A, AMP_4A, AMP_4A, 2'b11};
		endcase
	endfunction

	// Pin function from the low index bits and the enable mode
	function automatic rsc_gpio_t gpio_lookup(input logic [FUNC_IDX_W-1:0] idx);
		if (idx[1:0] == 2'h1)
			gpio_lookup = GPIO_SYNC_IN;
		else if (idx[1:0] == 2'h2)
			gpio_lookup = GPIO_CLK_OUT;
		else if (idx[FS_SEQ_BIT])
			gpio_lookup = GPIO_UNDERVOLT;
		else
			gpio_lookup = GPIO_POWER_GOOD;
	endfunction

	wire logic [13:0] cap_word = cap_lookup(cap_idx);
	wire logic        any_pair = cap_word[1] | cap_word[0];

	// Paired channels cannot use the grouped sequencer
	assign cfg.amps            = cap_word[13:2];
	assign cfg.pair12          = cap_word[1];
	assign cfg.pair34          = cap_word[0];
	assign cfg.seq_mode        = func_idx[FS_SEQ_BIT] & ~any_pair;
	assign cfg.timer_x8        = func_idx[FS_X8_BIT];
	assign cfg.power_save_mode = (func_idx[1:0] == FS_PSM_SEL);
	assign cfg.gpio            = gpio_lookup(func_idx);
endmodule

// ==== design/rsc_switch_seq.sv ====
// Per-cycle switch sequencer for one buck channel.
// Assumes analog events arrive as pulses or levels synchronous to pclk.
`timescale 1ns/1ns
module rsc_switch_seq
	import rsc_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic run,
	input  wire logic psm_cfg,
	// Analog events
	input  wire logic osc_tick,
	input  wire logic peak_trip,
	input  wire logic zero_cross,
	input  wire logic below_reg,
	input  wire logic light_load,
	// Switch drives
	output logic      hs_on,
	output logic      ls_on
);
	rsc_sw_t state_reg;
	rsc_sw_t state_next;

	// Fixed frequency unless power-save is idling at light load
	wire logic burst_ok = ~(psm_cfg & light_load) | below_reg;

	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SW_IDLE: begin
				if (run && osc_tick && burst_ok)
					state_next = SW_HIGH;
			end
			SW_HIGH: begin
				if (!run)
					state_next = SW_IDLE;
				else if (peak_trip)
					state_next = SW_LOW;
			end
			SW_LOW: begin
				if (!run)
					state_next = SW_IDLE;
				else if (osc_tick)
					state_next = burst_ok ? SW_HIGH : SW_IDLE;
				else if (psm_cfg && zero_cross)
					state_next = SW_IDLE;
			end
			default: state_next = SW_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= SW_IDLE;
		else
			state_reg <= state_next;
	end

	// Drives straight off the state flops
	assign hs_on = (state_reg == SW_HIGH);
	assign ls_on = (state_reg == SW_LOW);

	hs_on_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(hs_on) |-> $past(osc_tick) && $past(run))
		else $error("high side rose without a cycle start");

	ccm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		ls_on && run && !psm_cfg && !osc_tick |=> ls_on)
		else $error("low side dropped in forced mode");

	dcm_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		ls_on && run && psm_cfg && zero_cross && !osc_tick |=> !ls_on && !hs_on)
		else $error("low side stayed on after zero crossing");

	psm_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!hs_on && psm_cfg && light_load && !below_reg |=> !hs_on)
		else $error("burst started while in regulation");
endmodule

// ==== bench/rsc_strap_model.sv ====
// Stand-in for the strap resistors and the analog quantiser.
// Assumes the bench picks a resistor row by index; codes settle a few clocks later.
`timescale 1ns/1ns
module rsc_strap_model
	import rsc_pkg::*;
(
	// Clock
	input  wire logic                  pclk,
	// Chosen resistor rows
	input  wire logic [CAP_IDX_W-1:0]  cap_sel,
	input  wire logic [FUNC_IDX_W-1:0] func_sel,
	// Quantised codes
	output logic [CAP_IDX_W-1:0]       capability_strap,
	output logic [FUNC_IDX_W-1:0]      function_strap
);
	logic [1:0]            settle = 2'h3;
	logic [CAP_IDX_W-1:0]  cap_q  = '0;
	logic [FUNC_IDX_W-1:0] func_q = '0;
	logic [CAP_IDX_W-1:0]  cap_last  = '0;
	logic [FUNC_IDX_W-1:0] func_last = '0;

	// Codes wander while the node settles, so a latch then is a hazard
	always @(posedge pclk) begin
		if (cap_sel != cap_last || func_sel != func_last) begin
			settle <= 2'h3;
		end else if (settle != 2'h0) begin
			settle <= settle - 2'h1;
		end
		cap_last  <= cap_sel;
		func_last <= func_sel;
		if (settle != 2'h0) begin
			cap_q  <= ~cap_q;
			func_q <= ~func_q;
		end else begin
			cap_q  <= cap_last;
			func_q <= func_last;
		end
	end

	assign capability_strap = cap_q;
	assign function_strap   = func_q;
endmodule

// ==== bench/test_regulator_strap_config_decoder.sv ====
// Self-checking bench for the strap configuration decoder top.
// Assumes the strap model on the strap inputs and a 20 MHz pclk.
`timescale 1ns/1ns
module test_regulator_strap_config_decoder
	import rsc_pkg::*;
;
	localparam int INIT_N = 8;
	localparam rsc_sense_t OSC   = '{osc_tick: 4'hf, default: '0};
	localparam rsc_sense_t PEAK  = '{peak_trip: 4'hf, default: '0};
	localparam rsc_sense_t ZERO  = '{zero_cross: 4'hf, default: '0};
	localparam rsc_sense_t BELOW = '{below_reg: 4'hf, default: '0};
	localparam rsc_sense_t LIGHT = '{light_load: 4'hf, default: '0};
	logic         pclk     = 1'b0;
	logic         presetn  = 1'b0;
	rsc_apb_req_t apb_req  = '0;
	rsc_apb_rsp_t apb_rsp;
	logic [2:0]   cap_sel  = '0;
	logic [3:0]   func_sel = '0;
	logic [2:0]   capability_strap;
	logic [3:0]   function_strap;
	logic [3:0]   en_pin   = 4'hf;
	rsc_sense_t   sense    = '0;
	rsc_sense_t   base     = '0;
	logic [3:0]   hs_drive;
	logic [3:0]   ls_drive;
	logic [3:0]   ffm;
	logic [3:0]   xf;
	logic         cfg_valid;
	rsc_cfg_t     cfg;
	rsc_cfg_t     e;
	logic [31:0]  rd;
	logic         err;
	int           fails    = 0;
	int           checked  = 0;
	int           cyc      = 0;
	int           n;

	// Clock and hang guard
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			print_verdict();
		end
	end

	rsc_strap_model straps (.pclk(pclk), .cap_sel(cap_sel), .func_sel(func_sel),
		.capability_strap(capability_strap), .function_strap(function_strap));

	rsc_strap_config #(.INIT_COUNT(INIT_N)) DUT (.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .capability_strap(capability_strap),
		.function_strap(function_strap), .en_pin(en_pin), .sense(sense),
		.hs_drive(hs_drive), .ls_drive(ls_drive), .cfg_valid(cfg_valid), .cfg(cfg),
		.forced_fixed_freq_mode(ffm));

	task automatic print_verdict();
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask

	// One APB transfer; no wait state count is assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask

	// Reset with new straps; cycle ticks during start-up must not switch
	task automatic start(input logic [2:0] c, input logic [3:0] f, input logic [3:0] en);
		@(posedge pclk);
		presetn <= 1'b0;
		cap_sel <= c;
		func_sel <= f;
		en_pin <= en;
		sense <= OSC;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (cfg_valid !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
			if (n == 3) sense <= base;
			#1 chk("early drives", 32'h0, {24'h0, ls_drive, hs_drive});
		end
		chk("init cycles", INIT_N - 1, n);
	endtask

	// One cycle of channel events, then drives {ls, hs}
	task automatic tick(input rsc_sense_t v, input logic [7:0] ex);
		@(posedge pclk);
		sense <= v | base;
		@(posedge pclk);
		sense <= base;
		#1 chk("drives", {24'h0, ex}, {24'h0, ls_drive, hs_drive});
	endtask

	// Expected settings per strap row; pairs report per-channel share
	function automatic rsc_cfg_t exp_cfg(input logic [2:0] c, input logic [3:0] f);
		rsc_cfg_t r;
		r = '0;
		r.amps = {AMP_2A, AMP_2A, AMP_4A, AMP_4A};
		case (c)
			3'h1: r.amps = {AMP_2A, AMP_2A, AMP_2A, AMP_4A};
			3'h2: r.amps = {AMP_1A, AMP_1A, AMP_2A, AMP_4A};
			3'h3: r.amps = {AMP_2A, AMP_2A, AMP_2A, AMP_2A};
			3'h4: r.amps = {AMP_1A, AMP_1A, AMP_2A, AMP_2A};
			default: ;
		endcase
		r.pair12 = c[2] & c[0];
		r.pair34 = c[2] & c[1];
		r.seq_mode = f[3] & ~(r.pair12 | r.pair34);
		r.timer_x8 = f[2];
		r.power_save_mode = (f[1:0] == 2'h3);
		case (f[1:0])
			2'h1: r.gpio = GPIO_SYNC_IN;
			2'h2: r.gpio = GPIO_CLK_OUT;
			default: r.gpio = f[3] ? GPIO_UNDERVOLT : GPIO_POWER_GOOD;
		endcase
		return r;
	endfunction

	initial begin
		// Every row of both straps, then strap changes after start-up
		for (int i = 0; i < 16; i++) begin
			start(i[2:0], i[3:0], 4'hf);
			e = exp_cfg(i[2:0], i[3:0]);
			xf = {{2{~e.power_save_mode | e.pair34}}, {2{~e.power_save_mode | e.pair12}}};
			chk("cfg", {13'h0, e}, {13'h0, cfg});
			chk("fixed mode", {28'h0, xf}, {28'h0, ffm});
			@(posedge pclk);
			cap_sel <= ~cap_sel;
			func_sel <= ~func_sel;
			repeat (8) @(posedge pclk);
			#1 chk("frozen cfg", {13'h0, e}, {13'h0, cfg});
		end
		// Register access, forced manual configuration
		start(3'h2, 4'h5, 4'hf);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h11, rd);
		apb(1'b0, ADDR_STRAP, 32'h0);
		chk("strap", 32'h52, rd);
		apb(1'b0, ADDR_DECODE, 32'h0);
		chk("decode", {13'h0, exp_cfg(3'h2, 4'h5)}, rd);
		apb(1'b1, ADDR_STATUS, 32'hff);
		chk("ro error", 32'h0, {31'h0, err});
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status kept", 32'h11, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped read", 32'h1, {rd[30:0], err});
		apb(1'b1, 8'h14, 32'h7);
		chk("unmapped write", 32'h1, {31'h0, err});
		apb(1'b0, ADDR_CHAN_EN, 32'h0);
		chk("chan_en reset", 32'hf, rd);
		apb(1'b1, ADDR_CHAN_EN, 32'h5);
		apb(1'b0, ADDR_CHAN_EN, 32'h0);
		chk("chan_en", 32'h5, rd);
		// Forced mode cycle on gated channels
		tick(OSC, 8'h05);
		tick(PEAK, 8'h50);
		tick(ZERO, 8'h50);
		apb(1'b0, ADDR_DRIVE, 32'h0);
		chk("drive reg", 32'h50, rd);
		apb(1'b1, ADDR_CHAN_EN, 32'hf);
		tick(OSC, 8'h0f);
		// Grouped turn-on against manual enable
		start(3'h0, 4'h8, 4'h1);
		tick(OSC, 8'h0f);
		start(3'h0, 4'h0, 4'h1);
		tick(OSC, 8'h01);
		// Power-save bursts at light load
		base = LIGHT;
		start(3'h0, 4'h3, 4'hf);
		tick(OSC, 8'h00);
		tick(OSC | BELOW, 8'h0f);
		tick(PEAK, 8'hf0);
		tick(ZERO, 8'h00);
		// Paired channels stay forced in a power-save setting
		start(3'h5, 4'h3, 4'hf);
		tick(OSC, 8'h03);
		tick(PEAK, 8'h30);
		tick(ZERO, 8'h30);
		print_verdict();
	end
endmodule
